// ### design/dofd_map.vh
/*
 Register offsets, field positions, class codes and reset values for the
 operand field decoder. Definitions only; included by the decoder top.
*/
`ifndef DOFD_MAP_VH
`define DOFD_MAP_VH

// APB byte offsets
`define DOFD_OFS_WORD0       8'h00
`define DOFD_OFS_WORD1       8'h04
`define DOFD_OFS_CTRL        8'h08
`define DOFD_OFS_FLAGS       8'h0c
`define DOFD_OFS_RES_CYCLE   8'h10
`define DOFD_OFS_RES_OPERAND 8'h14
`define DOFD_OFS_RES_REGS    8'h18
`define DOFD_OFS_RES_DSP     8'h1c

// Reset values
`define DOFD_RST_WORD        24'h000000
`define DOFD_RST_CTRL        10'h000
`define DOFD_RST_FLAGS       9'h000

// Control register fields
`define DOFD_CTRL_CLASS_HI   3
`define DOFD_CTRL_CLASS_LO   0
`define DOFD_CTRL_SIZE_HI    5
`define DOFD_CTRL_SIZE_LO    4
`define DOFD_CTRL_TWO_WORD   6
`define DOFD_CTRL_SKIP       7
`define DOFD_CTRL_SKIP_TWO   8
`define DOFD_CTRL_ALONE      9

// Operand classes
`define DOFD_CLS_FILE        4'h0
`define DOFD_CLS_BIT         4'h1
`define DOFD_CLS_ULIT        4'h2
`define DOFD_CLS_SLIT        4'h3
`define DOFD_CLS_PADDR       4'h4
`define DOFD_CLS_MAC         4'h5
`define DOFD_CLS_SQR         4'h6
`define DOFD_CLS_DIV         4'h7
`define DOFD_CLS_TRIREG      4'h8
`define DOFD_CLS_MOVD        4'h9

// Size suffix codes
`define DOFD_SIZE_DEFAULT    2'h0
`define DOFD_SIZE_BYTE       2'h1
`define DOFD_SIZE_WORD       2'h2
`define DOFD_SIZE_DWORD      2'h3

// Instruction word layout
`define DOFD_OPC_HI          23
`define DOFD_OPC_LO          16
`define DOFD_BYTE_LIT_MAX    10'h0ff

// Working registers with fixed roles
`define DOFD_W0              4'h0
`define DOFD_W4              4'h4
`define DOFD_W8              4'h8
`define DOFD_W9              4'h9
`define DOFD_W12             4'hc
`define DOFD_W13             4'hd

// Write-back targets
`define DOFD_WBACK_NONE      2'h0
`define DOFD_WBACK_REG       2'h1
`define DOFD_WBACK_POSTINC   2'h2

// Cycle counts
`define DOFD_CYC_ONE         2'h1
`define DOFD_CYC_TWO         2'h2
`define DOFD_CYC_THREE       2'h3

`endif

// ### design/dofd_decoder.v
/*
 Operand field decoder for a 16-bit DSP controller core: splits a one or
 two word instruction into opcode, literal, register, addressing and DSP
 operand fields, works out the cycle count and holds the status flags.
 Assumes an APB master on ref_clk_in and an execution datapath on the same
 clock that reports flag updates through datapath_flags_*.
*/
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dofd_map.vh"

module dofd_decoder (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        rst_b_in,
   // APB slave
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output reg         pready_out,
   output reg         pslverr_out,
   // Flag updates from the datapath
   input  wire        datapath_flags_we_in,
   input  wire [8:0]  datapath_flags_in,
   // Decoded instruction
   output reg         decode_valid_out,
   output reg  [7:0]  opcode_out,
   output reg  [1:0]  cycle_count_out,
   output reg         nop_out,
   output reg         illegal_out,
   output reg  [1:0]  size_out,
   output reg  [15:0] operand_value_out,
   output reg  [22:0] program_address_immediate_out,
   output reg  [15:0] bit_mask_out,
   output reg  [3:0]  base_working_reg_out,
   output reg  [3:0]  src_reg_out,
   output reg  [3:0]  dst_reg_out,
   output reg  [2:0]  addr_mode_out,
   output reg         accum_sel_out,
   output reg  [1:0]  accum_writeback_target_out,
   output reg  [3:0]  mul_reg_a_out,
   output reg  [3:0]  mul_reg_b_out,
   output reg         x_prefetch_en_out,
   output reg  [3:0]  x_prefetch_pointer_out,
   output reg  [3:0]  x_prefetch_mod_out,
   output reg         x_prefetch_w12_out,
   output reg  [3:0]  x_dest_reg_out,
   output reg  [3:0]  y_dest_reg_out,
   // Status flags
   output reg  [8:0]  flags_out
);

   reg  [23:0] instr_word0;
   reg  [23:0] instr_word1;
   reg  [9:0]  ctrl;
   reg         decode_pending;

   wire        apb_setup  = psel_in & ~penable_in;
   wire        apb_access = psel_in & penable_in & pready_out;
   wire        apb_wr     = apb_access & pwrite_in;
   wire [3:0]  cls        = ctrl[`DOFD_CTRL_CLASS_HI:`DOFD_CTRL_CLASS_LO];
   wire [1:0]  size_field = ctrl[`DOFD_CTRL_SIZE_HI:`DOFD_CTRL_SIZE_LO];
   wire [15:0] ops        = instr_word0[15:0];

   reg         addr_hit;
   reg  [31:0] next_prdata;
   reg  [7:0]  next_opcode;
   reg  [1:0]  next_cycles;
   reg         next_nop;
   reg         next_illegal;
   reg  [1:0]  next_size;
   reg  [15:0] next_operand;
   reg  [22:0] next_prog_addr;
   reg  [15:0] next_bit_mask;
   reg  [3:0]  next_base;
   reg  [3:0]  next_src;
   reg  [3:0]  next_dst;
   reg  [2:0]  next_mode;
   reg         next_acc;
   reg  [1:0]  next_wback;
   reg  [3:0]  next_mul_a;
   reg  [3:0]  next_mul_b;
   reg         next_xpf_en;
   reg  [3:0]  next_xpf_ptr;
   reg  [3:0]  next_xpf_mod;
   reg         next_xpf_w12;
   reg  [3:0]  next_xd;
   reg  [3:0]  next_yd;
   reg  [9:0]  ten_bit_lit;
   reg  [2:0]  pf_low;

   // Registers written by software; these steer the decode
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         instr_word0    <= `DOFD_RST_WORD;
         instr_word1    <= `DOFD_RST_WORD;
         ctrl           <= `DOFD_RST_CTRL;
         decode_pending <= 1'b0;
      end else begin
         decode_pending <= 1'b0;
         if (apb_wr) begin
            case (paddr_in)
               `DOFD_OFS_WORD0: begin
                  instr_word0    <= pwdata_in[23:0];
                  decode_pending <= 1'b1;
               end
               `DOFD_OFS_WORD1: instr_word1 <= pwdata_in[23:0];
               `DOFD_OFS_CTRL:  ctrl        <= pwdata_in[9:0];
               default: ;
            endcase
         end
      end
   end

   // Datapath update wins over a software write in the same cycle
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flags_out <= `DOFD_RST_FLAGS;
      end else if (datapath_flags_we_in) begin
         flags_out <= datapath_flags_in;
      end else if (apb_wr && paddr_in == `DOFD_OFS_FLAGS) begin
         flags_out <= pwdata_in[8:0];
      end
   end

   // Operand decode
   always @* begin
      ten_bit_lit    = ops[13:4];
      pf_low         = 3'h0;
      next_opcode    = instr_word0[`DOFD_OPC_HI:`DOFD_OPC_LO];
      next_nop       = 1'b0;
      next_illegal   = 1'b0;
      next_size      = size_field;
      next_operand   = 16'h0000;
      next_prog_addr = 23'h000000;
      next_bit_mask  = 16'h0000;
      next_base      = 4'h0;
      next_src       = 4'h0;
      next_dst       = 4'h0;
      next_mode      = 3'h0;
      next_acc       = 1'b0;
      next_wback     = `DOFD_WBACK_NONE;
      next_mul_a     = 4'h0;
      next_mul_b     = 4'h0;
      next_xpf_en    = 1'b0;
      next_xpf_ptr   = 4'h0;
      next_xpf_mod   = 4'h0;
      next_xpf_w12   = 1'b0;
      next_xd        = 4'h0;
      next_yd        = 4'h0;
      if (size_field == `DOFD_SIZE_DEFAULT) begin
         next_size = `DOFD_SIZE_WORD;
      end
      case (cls)
         `DOFD_CLS_FILE: begin
            next_operand = {3'h0, ops[12:0]};
            next_src     = `DOFD_W0;
            next_dst     = `DOFD_W0;
            next_mode    = {2'h0, ops[13]};
         end
         `DOFD_CLS_BIT: begin
            next_src      = ops[7:4];
            next_operand  = {12'h000, ops[3:0]};
            next_bit_mask = 16'h0001 << ops[3:0];
         end
         `DOFD_CLS_ULIT: begin
            next_dst     = ops[3:0];
            next_operand = {6'h00, ten_bit_lit};
            if (next_size == `DOFD_SIZE_BYTE && ten_bit_lit > `DOFD_BYTE_LIT_MAX) begin
               next_illegal = 1'b1;
               next_operand = {8'h00, ten_bit_lit[7:0]};
            end
         end
         `DOFD_CLS_SLIT: begin
            next_dst     = ops[3:0];
            next_operand = {{6{ten_bit_lit[9]}}, ten_bit_lit};
         end
         `DOFD_CLS_PADDR: begin
            next_prog_addr = {instr_word1[6:0], ops[15:1], 1'b0};
            if (ops[0] || !ctrl[`DOFD_CTRL_TWO_WORD]) begin
               next_illegal = 1'b1;
            end
         end
         `DOFD_CLS_MAC, `DOFD_CLS_SQR: begin
            next_acc = ops[15];
            case (ops[14:13])
               2'h1:    next_wback = `DOFD_WBACK_REG;
               2'h2:    next_wback = `DOFD_WBACK_POSTINC;
               2'h0:    next_wback = `DOFD_WBACK_NONE;
               default: next_illegal = 1'b1;
            endcase
            if (cls == `DOFD_CLS_SQR) begin
               next_mul_a = `DOFD_W4 + {2'h0, ops[11:10]};
               next_mul_b = `DOFD_W4 + {2'h0, ops[11:10]};
               if (ops[12]) begin
                  next_illegal = 1'b1;
               end
            end else begin
               case (ops[12:10])
                  3'h0: begin next_mul_a = 4'h4; next_mul_b = 4'h5; end
                  3'h1: begin next_mul_a = 4'h4; next_mul_b = 4'h6; end
                  3'h2: begin next_mul_a = 4'h4; next_mul_b = 4'h7; end
                  3'h3: begin next_mul_a = 4'h5; next_mul_b = 4'h6; end
                  3'h4: begin next_mul_a = 4'h5; next_mul_b = 4'h7; end
                  3'h5: begin next_mul_a = 4'h6; next_mul_b = 4'h7; end
                  default: next_illegal = 1'b1;
               endcase
            end
            // Codes 0-6 use W8, 7-13 use W9; each run is +6,+4,+2,0,-6,-4,-2
            if (ops[9:6] == 4'hf) begin
               next_xpf_en = 1'b0;
            end else if (ops[9:6] == 4'he) begin
               next_xpf_en  = 1'b1;
               next_xpf_ptr = `DOFD_W9;
               next_xpf_w12 = 1'b1;
            end else begin
               next_xpf_en  = 1'b1;
               next_xpf_ptr = (ops[9:6] < 4'h7) ? `DOFD_W8 : `DOFD_W9;
               pf_low       = (ops[9:6] < 4'h7) ? ops[8:6] : ops[8:6] + 3'h1;
               case (pf_low)
                  3'h0:    next_xpf_mod = 4'h6;
                  3'h1:    next_xpf_mod = 4'h4;
                  3'h2:    next_xpf_mod = 4'h2;
                  3'h3:    next_xpf_mod = 4'h0;
                  3'h4:    next_xpf_mod = 4'ha;
                  3'h5:    next_xpf_mod = 4'hc;
                  default: next_xpf_mod = 4'he;
               endcase
            end
            next_xd = `DOFD_W4 + {2'h0, ops[5:4]};
            next_yd = `DOFD_W4 + {2'h0, ops[3:2]};
         end
         `DOFD_CLS_DIV: begin
            next_src  = ops[7:4];
            next_dst  = ops[3:0];
            next_base = ops[7:4];
            next_mode = 3'h0;
            if (ops[14:12] != 3'h0) begin
               next_illegal = 1'b1;
            end
         end
         `DOFD_CLS_TRIREG, `DOFD_CLS_MOVD: begin
            next_mode = ops[14:12];
            next_base = ops[11:8];
            next_src  = ops[7:4];
            next_dst  = ops[3:0];
            next_acc  = ops[15];
            if (ops[14:12] == 3'h7) begin
               next_illegal = 1'b1;
            end
            if (cls == `DOFD_CLS_MOVD) begin
               next_size = `DOFD_SIZE_DWORD;
            end
         end
         default: next_illegal = 1'b1;
      endcase
      if (size_field == `DOFD_SIZE_DWORD && cls != `DOFD_CLS_MOVD &&
          cls != `DOFD_CLS_TRIREG) begin
         next_illegal = 1'b1;
      end
      // Second word needs a clear opcode byte
      if (ctrl[`DOFD_CTRL_TWO_WORD] &&
          instr_word1[`DOFD_OPC_HI:`DOFD_OPC_LO] != 8'h00) begin
         next_illegal = 1'b1;
      end
      // Cycle count; a skip overrides the instruction's own cost
      if (ctrl[`DOFD_CTRL_SKIP]) begin
         next_cycles = ctrl[`DOFD_CTRL_SKIP_TWO] ? `DOFD_CYC_THREE : `DOFD_CYC_TWO;
      end else if (ctrl[`DOFD_CTRL_TWO_WORD]) begin
         next_cycles = `DOFD_CYC_TWO;
      end else if (next_size == `DOFD_SIZE_DWORD) begin
         next_cycles = `DOFD_CYC_TWO;
      end else begin
         next_cycles = `DOFD_CYC_ONE;
      end
      // A lone second word decodes to a do-nothing single cycle
      if (ctrl[`DOFD_CTRL_ALONE]) begin
         next_cycles  = `DOFD_CYC_ONE;
         next_nop     = (instr_word0[`DOFD_OPC_HI:`DOFD_OPC_LO] == 8'h00);
         next_illegal = ~next_nop;
      end
   end

   // Decoded results, refreshed every cycle
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         decode_valid_out              <= 1'b0;
         opcode_out                    <= 8'h00;
         cycle_count_out               <= `DOFD_CYC_ONE;
         nop_out                       <= 1'b0;
         illegal_out                   <= 1'b0;
         size_out                      <= `DOFD_SIZE_WORD;
         operand_value_out             <= 16'h0000;
         program_address_immediate_out <= 23'h000000;
         bit_mask_out                  <= 16'h0000;
         base_working_reg_out          <= 4'h0;
         src_reg_out                   <= 4'h0;
         dst_reg_out                   <= 4'h0;
         addr_mode_out                 <= 3'h0;
         accum_sel_out                 <= 1'b0;
         accum_writeback_target_out    <= `DOFD_WBACK_NONE;
         mul_reg_a_out                 <= 4'h0;
         mul_reg_b_out                 <= 4'h0;
         x_prefetch_en_out             <= 1'b0;
         x_prefetch_pointer_out        <= 4'h0;
         x_prefetch_mod_out            <= 4'h0;
         x_prefetch_w12_out            <= 1'b0;
         x_dest_reg_out                <= 4'h0;
         y_dest_reg_out                <= 4'h0;
      end else begin
         decode_valid_out              <= decode_pending;
         opcode_out                    <= next_opcode;
         cycle_count_out               <= next_cycles;
         nop_out                       <= next_nop;
         illegal_out                   <= next_illegal;
         size_out                      <= next_size;
         operand_value_out             <= next_operand;
         program_address_immediate_out <= next_prog_addr;
         bit_mask_out                  <= next_bit_mask;
         base_working_reg_out          <= next_base;
         src_reg_out                   <= next_src;
         dst_reg_out                   <= next_dst;
         addr_mode_out                 <= next_mode;
         accum_sel_out                 <= next_acc;
         accum_writeback_target_out    <= next_wback;
         mul_reg_a_out                 <= next_mul_a;
         mul_reg_b_out                 <= next_mul_b;
         x_prefetch_en_out             <= next_xpf_en;
         x_prefetch_pointer_out        <= next_xpf_ptr;
         x_prefetch_mod_out            <= next_xpf_mod;
         x_prefetch_w12_out            <= next_xpf_w12;
         x_dest_reg_out                <= next_xd;
         y_dest_reg_out                <= next_yd;
      end
   end

   // Read mux
   always @* begin
      addr_hit    = 1'b1;
      next_prdata = 32'h00000000;
      case (paddr_in)
         `DOFD_OFS_WORD0:       next_prdata = {8'h00, instr_word0};
         `DOFD_OFS_WORD1:       next_prdata = {8'h00, instr_word1};
         `DOFD_OFS_CTRL:        next_prdata = {22'h000000, ctrl};
         `DOFD_OFS_FLAGS:       next_prdata = {23'h000000, flags_out};
         `DOFD_OFS_RES_CYCLE:   next_prdata = {16'h0000, opcode_out, 1'b0, size_out,
                                               illegal_out, nop_out, 1'b0,
                                               cycle_count_out};
         `DOFD_OFS_RES_OPERAND: next_prdata = {bit_mask_out, operand_value_out};
         `DOFD_OFS_RES_REGS:    next_prdata = {17'h00000, addr_mode_out,
                                               base_working_reg_out, src_reg_out,
                                               dst_reg_out};
         `DOFD_OFS_RES_DSP:     next_prdata = {1'b0, accum_sel_out,
                                               accum_writeback_target_out,
                                               mul_reg_a_out, mul_reg_b_out,
                                               x_prefetch_en_out, x_prefetch_w12_out,
                                               2'h0, x_prefetch_pointer_out,
                                               x_prefetch_mod_out, x_dest_reg_out,
                                               y_dest_reg_out};
         default:               addr_hit = 1'b0;
      endcase
   end

   // No wait states: pready rises in the first access cycle
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h00000000;
      end else if (apb_setup) begin
         pready_out  <= 1'b1;
         pslverr_out <= ~addr_hit;
         prdata_out  <= pwrite_in ? 32'h00000000 : next_prdata;
      end else begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h00000000;
      end
   end

endmodule

// ### sim/dofd_monitor.sv
/*
 Port checker for the operand field decoder.
 Assumes the decoder top below; attached by the bind at the foot.
*/
`timescale 1ns/1ps
module dofd_monitor (
   // Clock, reset and bus
   input wire        ref_clk_in,
   input wire        rst_b_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [7:0]  paddr_in,
   input wire        pready_out,
   // Decode outputs and flags
   input wire        decode_valid_out,
   input wire        illegal_out,
   input wire [1:0]  cycle_count_out,
   input wire [1:0]  size_out,
   input wire [22:0] program_address_immediate_out,
   input wire [15:0] bit_mask_out,
   input wire [1:0]  accum_writeback_target_out,
   input wire [3:0]  mul_reg_a_out,
   input wire [3:0]  mul_reg_b_out,
   input wire        x_prefetch_en_out,
   input wire [3:0]  x_prefetch_pointer_out,
   input wire        x_prefetch_w12_out,
   input wire [3:0]  x_dest_reg_out,
   input wire        datapath_flags_we_in,
   input wire [8:0]  datapath_flags_in,
   input wire [8:0]  flags_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   cycle_range_a:
      assert property (cycle_count_out != 2'h0) else $error("cycle count zero");
   size_known_a:
      assert property (size_out != 2'h0) else $error("size code zero");
   mask_onehot_a:
      assert property ($onehot0(bit_mask_out)) else $error("bit mask not one-hot");
   paddr_even_a:
      assert property (!program_address_immediate_out[0]) else $error("odd address");
   wback_target_a:
      assert property (accum_writeback_target_out != 2'h3) else $error("bad write-back");
   mul_pair_a:
      assert property (!illegal_out && mul_reg_a_out != 4'h0 |-> mul_reg_b_out[3:2] == 2'b01
         && mul_reg_a_out <= mul_reg_b_out) else $error("bad multiply pair");
   xdest_range_a:
      assert property (x_dest_reg_out == 4'h0 || x_dest_reg_out[3:2] == 2'b01)
         else $error("x destination out of range");
   xptr_src_a:
      assert property (x_prefetch_en_out |-> x_prefetch_pointer_out[3:1] == 3'b100)
         else $error("bad prefetch pointer");
   xptr_offset_a:
      assert property (x_prefetch_w12_out |-> x_prefetch_pointer_out == 4'h9)
         else $error("offset prefetch not from upper pointer");
   flag_load_a:
      assert property (datapath_flags_we_in |=> flags_out == $past(datapath_flags_in))
         else $error("flags not loaded");
   decode_pulse_a:
      assert property (psel_in && penable_in && pwrite_in && pready_out && paddr_in == 8'h00
         |-> ##2 decode_valid_out) else $error("no decode pulse");
endmodule

bind dofd_decoder dofd_monitor i_mon (.ref_clk_in, .rst_b_in, .psel_in, .penable_in,
   .pwrite_in, .paddr_in, .pready_out, .decode_valid_out, .illegal_out, .cycle_count_out,
   .size_out, .program_address_immediate_out, .bit_mask_out, .accum_writeback_target_out,
   .mul_reg_a_out, .mul_reg_b_out, .x_prefetch_en_out, .x_prefetch_pointer_out,
   .x_prefetch_w12_out, .x_dest_reg_out, .datapath_flags_we_in, .datapath_flags_in,
   .flags_out);

// ### sim/dofd_datapath_model.sv
/*
 Datapath stand-in that reports flag updates to the decoder.
 Assumes the bench asks for one update at a time on the core clock.
*/
`timescale 1ns/1ps
module dofd_datapath_model (
   // Clock and reset
   input  wire       ref_clk_in,
   input  wire       rst_b_in,
   // Bench request
   input  wire       req_in,
   input  wire [8:0] val_in,
   // Flag update
   output reg        flags_we_out,
   output reg  [8:0] flags_out
);
   // Five arithmetic flags low, four accumulator flags high
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flags_we_out <= 1'b0;
         flags_out    <= 9'h000;
      end else begin
         flags_we_out <= req_in;
         // Idle data toggles so a stale value never passes for a load
         flags_out    <= req_in ? val_in : ~flags_out;
      end
   end
endmodule

// ### sim/testbench.sv
/*
 Self-checking bench for the operand field decoder.
 Assumes the decoder, its checker and the datapath model alongside.
*/
`timescale 1ns/1ps
`include "dofd_map.vh"
module testbench;
   logic        ref_clk_in = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic        req = 0, err, decode_valid_out, nop_out, illegal_out, pready_out, pslverr_out;
   logic        accum_sel_out, x_prefetch_en_out, x_prefetch_w12_out, datapath_flags_we_in;
   logic [7:0]  paddr_in = 0, opcode_out;
   logic [31:0] pwdata_in = 0, prdata_out, rd;
   logic [8:0]  fval = 0, datapath_flags_in, flags_out;
   logic [1:0]  cycle_count_out, size_out, accum_writeback_target_out;
   logic [15:0] operand_value_out, bit_mask_out;
   logic [22:0] program_address_immediate_out;
   logic [2:0]  addr_mode_out;
   logic [3:0]  base_working_reg_out, src_reg_out, dst_reg_out, mul_reg_a_out, mul_reg_b_out;
   logic [3:0]  x_prefetch_pointer_out, x_prefetch_mod_out, x_dest_reg_out, y_dest_reg_out;
   logic [7:0]  pairs [6] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};
   logic [3:0]  mods [7] = '{4'h6, 4'h4, 4'h2, 4'h0, 4'ha, 4'hc, 4'he};
   logic [9:0]  cct [7] = '{10'h0a0, 10'h1a0, 10'h029, 10'h060, 10'h220, 10'h220, 10'h060};
   logic [3:0]  cexp [7] = '{4'h2, 4'h3, 4'h2, 4'h2, 4'h9, 4'h5, 4'h6};
   int          n_fail = 0, total_checks = 0;

   dofd_decoder i_dut (.ref_clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .datapath_flags_we_in,
      .datapath_flags_in, .decode_valid_out, .opcode_out, .cycle_count_out, .nop_out,
      .illegal_out, .size_out, .operand_value_out, .program_address_immediate_out,
      .bit_mask_out, .base_working_reg_out, .src_reg_out, .dst_reg_out, .addr_mode_out,
      .accum_sel_out, .accum_writeback_target_out, .mul_reg_a_out, .mul_reg_b_out,
      .x_prefetch_en_out, .x_prefetch_pointer_out, .x_prefetch_mod_out, .x_prefetch_w12_out,
      .x_dest_reg_out, .y_dest_reg_out, .flags_out);
   dofd_datapath_model i_dp (.ref_clk_in, .rst_b_in, .req_in(req), .val_in(fval),
      .flags_we_out(datapath_flags_we_in), .flags_out(datapath_flags_in));

   initial begin
      forever #2 ref_clk_in = ~ref_clk_in;
   end

   task automatic end_sim;
      if (n_fail == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= wr;
      paddr_in   <= a;
      pwdata_in  <= d;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      do @(posedge ref_clk_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // Word0 last, so its write launches the decode
   task automatic dec(input logic [23:0] w0, input logic [23:0] w1, input logic [9:0] c);
      apb(1'b1, `DOFD_OFS_WORD1, {8'h00, w1});
      apb(1'b1, `DOFD_OFS_CTRL, {22'h0, c});
      apb(1'b1, `DOFD_OFS_WORD0, {8'h00, w0});
      @(posedge ref_clk_in);
      #1;
   endtask

   task automatic tv(input logic [23:0] w0, input logic [9:0] c, input logic [15:0] op,
                     input logic il);
      dec(w0, 24'h0, c);
      chk({operand_value_out, illegal_out, cycle_count_out}, {op, il, 2'h1});
   endtask

   initial begin
      repeat (20) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      apb(1'b0, `DOFD_OFS_FLAGS, 32'h0);
      chk({rd, size_out}, {32'h0, 2'h2});
      tv(24'h003ff5, 10'h002, 16'h03ff, 1'b0);
      chk(size_out, 2'h2);
      tv(24'h003ff5, 10'h022, 16'h03ff, 1'b0);
      tv(24'h000ff5, 10'h012, 16'h00ff, 1'b0);
      tv(24'h001005, 10'h012, 16'h0000, 1'b1);
      tv(24'h002005, 10'h023, 16'hfe00, 1'b0);
      tv(24'h001ff5, 10'h023, 16'h01ff, 1'b0);
      for (int m = 0; m < 8; m++) begin
         dec({8'h00, 1'b0, m[2:0], 12'hfed}, 24'h0, 10'h028);
         chk(illegal_out, m == 7);
         if (m < 7) chk({addr_mode_out, base_working_reg_out, src_reg_out, dst_reg_out},
                        {m[2:0], 12'hfed});
      end
      tv(24'h001fff, 10'h020, 16'h1fff, 1'b0);
      chk({src_reg_out, dst_reg_out}, 8'h00);
      for (int b = 0; b < 16; b++) begin
         dec({16'h0000, 4'h3, b[3:0]}, 24'h0, 10'h021);
         chk({src_reg_out, bit_mask_out}, {4'h3, 16'h0001 << b});
      end
      dec(24'h0000a3, 24'h0, 10'h027);
      chk({illegal_out, base_working_reg_out, src_reg_out, dst_reg_out}, 13'h0aa3);
      dec(24'h0010a3, 24'h0, 10'h027);
      chk(illegal_out, 1'b1);
      dec(24'h00fffe, 24'h00007f, 10'h064);
      chk({program_address_immediate_out, illegal_out, cycle_count_out},
          {23'h7ffffe, 1'b0, 2'h2});
      apb(1'b0, `DOFD_OFS_RES_REGS, 32'h0);
      chk(rd, 32'h0);
      dec(24'h00ffff, 24'h00007f, 10'h064);
      chk(illegal_out, 1'b1);
      for (int i = 0; i < 7; i++) begin
         dec({i == 5 ? 8'h12 : 8'h00, 16'h0}, {i == 6 ? 8'h01 : 8'h00, 16'h0}, cct[i]);
         chk({nop_out, illegal_out, cycle_count_out}, cexp[i]);
         chk(opcode_out, i == 5 ? 8'h12 : 8'h00);
      end
      for (int i = 0; i < 16; i++) begin
         dec({8'h00, i[0], 2'(i % 3), 3'(i % 6), i[3:0], i[1:0], ~i[1:0], 2'b00}, 24'h0,
             10'h025);
         chk({accum_sel_out, accum_writeback_target_out}, {i[0], 2'(i % 3)});
         chk({mul_reg_a_out, mul_reg_b_out}, pairs[i % 6]);
         chk({x_dest_reg_out, y_dest_reg_out}, {2'b01, i[1:0], 2'b01, ~i[1:0]});
         chk(x_prefetch_en_out, i != 15);
         if (i < 14) chk({x_prefetch_pointer_out, x_prefetch_mod_out},
                         {i < 7 ? 4'h8 : 4'h9, mods[i % 7]});
         if (i == 14) chk({x_prefetch_pointer_out, x_prefetch_w12_out}, 5'h13);
      end
      for (int k = 0; k < 4; k++) begin
         dec({8'h00, 4'h0, k[1:0], 10'h000}, 24'h0, 10'h026);
         chk({mul_reg_a_out, mul_reg_b_out}, {2{2'b01, k[1:0]}});
      end
      for (int f = 0; f < 9; f++) begin
         @(posedge ref_clk_in);
         req  <= 1'b1;
         fval <= 9'h001 << f;
         @(posedge ref_clk_in);
         req  <= 1'b0;
         apb(1'b0, `DOFD_OFS_FLAGS, 32'h0);
         chk(rd, 32'h1 << f);
      end
      apb(1'b0, 8'h20, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      end_sim;
   end

   // Whole sequence needs well under a thousand cycles
   initial begin
      #50000;
      n_fail++;
      end_sim;
   end
endmodule
